//--- tb/cell_balance_write_guard_assertions.sv
// Port-level checker for the balancing write guard
`timescale 1ns/100ps
`default_nettype none
module cell_balance_write_guard_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Register bus
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Scan controller and switches
  input wire logic        acqRequest,
  input wire logic        measStart,
  input wire logic        settling,
  input wire logic        uvExitEnable,
  input wire logic [13:0] dischargeSwitch
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  AST_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request waited more than one cycle");
  AST_IDLE_NO_WAIT: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest without request");
  AST_READ_HOLD: assert property (!$past(read) |-> $stable(readdata))
    else $error("readdata moved without a read");
  // Switch flops follow the mode one cycle late, so check from auto's second cycle
  AST_AUTO_OFF: assert property (uvExitEnable && $past(uvExitEnable) |-> dischargeSwitch == 14'h0)
    else $error("switch on in auto mode");
  AST_SETTLE_OFF: assert property (settling |=> dischargeSwitch == 14'h0)
    else $error("switch on while settling");
  AST_START_PULSE: assert property (measStart |=> !measStart)
    else $error("measStart longer than one cycle");
  AST_START_AFTER: assert property ($fell(settling) |-> ##[0:1] measStart)
    else $error("no measStart after settling");
  AST_ACQ_REACT: assert property (acqRequest && !settling |-> ##[1:2] (settling || measStart))
    else $error("acquisition request not acted on");

  C_START: cover property (measStart);
  C_SETTLE: cover property ($rose(settling));
  C_SWITCH: cover property (dischargeSwitch != 14'h0);
endmodule // cell_balance_write_guard_checker

bind cell_balance_write_guard cell_balance_write_guard_checker chk_i (
  .mclk, .rst, .read, .write, .readdata, .waitrequest, .acqRequest,
  .measStart, .settling, .uvExitEnable, .dischargeSwitch
);
`default_nettype wire

//--- tb/testbench.sv
// Self-checking testbench for the balancing write guard
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  address = 8'h00;
  logic [3:0]  byteenable = 4'hf;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic        measBusy = 1'b0;
  logic        acqRequest = 1'b0;
  logic [31:0] readdata;
  logic        waitrequest, measStart, settling, uvExitEnable;
  logic [13:0] dischargeSwitch;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc = 0;
  logic [31:0] d;
  logic [7:0]  offs [6] = '{8'h04, 8'h08, 8'h3c, 8'h40, 8'h44, 8'h48};
  logic [2:0]  modes [5] = '{3'h4, 3'h7, 3'h2, 3'h3, 3'h1};

  cell_balance_write_guard #(.TICK_CYCLES(20)) uut (
    .mclk(mclk), .rst(rst), .address(address), .byteenable(byteenable), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .measBusy(measBusy), .acqRequest(acqRequest), .measStart(measStart),
    .settling(settling), .uvExitEnable(uvExitEnable), .dischargeSwitch(dischargeSwitch)
  );

  initial begin
    forever #50 mclk = ~mclk;
  end

  // ------------------------------------------------------------------
  // Bus, compare and closing tasks
  // ------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    address <= a;
    writedata <= v;
    write <= 1'b1;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    address <= a;
    read <= 1'b1;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    v = readdata;
    read <= 1'b0;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Write accepted by the guard in a given mode
  function automatic logic acc(input logic [2:0] m, input logic [7:0] a);
    return !(m[2] || a == 8'h08 || (m == 3'h1 && a == 8'h44));
  endfunction

  // Acquisition pulse, then settling length and start pulse
  task automatic settle(input logic [31:0] cfg, input int exp);
    int n;
    n = 0;
    wr(8'h4c, cfg);
    @(posedge mclk);
    acqRequest <= 1'b1;
    @(posedge mclk);
    acqRequest <= 1'b0;
    @(negedge mclk);
    if (exp == 0) chk("measStart", 32'h1, measStart);
    while (settling === 1'b1 && n < 20000) begin
      n++;
      @(negedge mclk);
    end
    chk("settle cycles", exp, n);
    if (exp != 0) chk("measStart", 32'h1, measStart);
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      test_done;
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h50, d);
    chk("status", 32'h0, d);
    rd(8'hfc, d);
    chk("unmapped", 32'h0, d);
    foreach (modes[mi]) begin
      wr(8'h00, 32'h0);
      foreach (offs[oi]) wr(offs[oi], 32'h0);
      wr(8'h00, {29'h0, modes[mi]});
      @(negedge mclk);
      chk("uvExitEnable", {31'h0, modes[mi][2]}, uvExitEnable);
      foreach (offs[oi]) begin
        wr(offs[oi], 32'h55);
        rd(offs[oi], d);
        if (offs[oi] == 8'h04) d = d & 32'h3fff;
        chk("readback", acc(modes[mi], offs[oi]) ? 32'h55 : 32'h0, d);
        rd(8'h50, d);
        chk("reject", {31'h0, !acc(modes[mi], offs[oi]) && offs[oi] != 8'h04}, d[0]);
        wr(8'h50, 32'h1);
      end
    end
    wr(8'h00, 32'h4);
    wr(8'h04, 32'h4000);
    rd(8'h50, d);
    chk("strobe reject", 32'h1, d[0]);
    // Manual watchdog, refresh and expiry
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h2);
    wr(8'h04, 32'h3fff);
    wr(8'h00, 32'h2);
    repeat (3) @(negedge mclk);
    chk("switch", 32'h3fff, dischargeSwitch);
    repeat (45) @(posedge mclk);
    wr(8'h04, 32'h7fff);
    repeat (40) @(negedge mclk);
    chk("switch", 32'h3fff, dischargeSwitch);
    repeat (60) @(negedge mclk);
    chk("switch", 32'h0, dischargeSwitch);
    rd(8'h50, d);
    chk("expired", 32'h1, d[1]);
    wr(8'h04, 32'h7fff);
    repeat (3) @(negedge mclk);
    chk("switch", 32'h0, dischargeSwitch);
    wr(8'h00, 32'h2);
    repeat (3) @(negedge mclk);
    chk("switch", 32'h3fff, dischargeSwitch);
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h3ff);
    wr(8'h00, 32'h2);
    repeat (150) @(negedge mclk);
    chk("switch", 32'h3fff, dischargeSwitch);
    wr(8'h4c, 32'h1);
    measBusy <= 1'b1;
    repeat (3) @(negedge mclk);
    chk("switch", 32'h0, dischargeSwitch);
    wr(8'h4c, 32'h0);
    repeat (3) @(negedge mclk);
    chk("switch", 32'h3fff, dischargeSwitch);
    // Lowest-cell target and settle lock during a scan
    wr(8'h00, 32'h0);
    wr(8'h40, 32'h8000);
    wr(8'h40, 32'h8123);
    rd(8'h40, d);
    chk("uv target", 32'h8000, d);
    wr(8'h50, 32'h1);
    wr(8'h48, 32'h1);
    rd(8'h50, d);
    chk("reject", 32'h1, d[0]);
    wr(8'h50, 32'h1);
    measBusy <= 1'b0;
    wr(8'h40, 32'h8123);
    rd(8'h40, d);
    chk("uv target", 32'h8123, d);
    // Byte lanes: only the written lane changes
    byteenable <= 4'h2;
    wr(8'h44, 32'hffff_ffff);
    byteenable <= 4'hf;
    rd(8'h44, d);
    chk("byte lanes", 32'h0000_ff00, d);
    // Settling delay selection, cell delay at the usual 960us
    wr(8'h48, 32'h0a01);
    settle(32'h1, 9600);
    settle(32'h3, 960);
    settle(32'h0, 0);
    test_done;
  end
endmodule // testbench
`default_nettype wire

//--- verilog/cell_balance_pkg.sv
// Shared constants for the cell-balancing write guard and switch control
`default_nettype none
package cell_balance_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_MODE        = 8'h00;
  localparam logic [7:0] OFF_SWCTRL      = 8'h04;
  localparam logic [7:0] OFF_EXP_FIRST   = 8'h08;
  localparam logic [7:0] OFF_EXP_LAST    = 8'h3c;
  localparam logic [7:0] OFF_UV_TARGET   = 8'h40;
  localparam logic [7:0] OFF_DELAY_CTRL  = 8'h44;
  localparam logic [7:0] OFF_SETTLE      = 8'h48;
  localparam logic [7:0] OFF_CONFIG      = 8'h4c;
  localparam logic [7:0] OFF_STATUS      = 8'h50;

  // ------------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------------
  localparam int         MODE_W          = 3;
  localparam int         CELLS           = 14;
  localparam int         EXP_W           = 10;
  localparam int         SW_RESTART_BIT  = 14;
  localparam int         SW_STATE_LSB    = 16;
  localparam int         UV_W            = 12;
  localparam int         UV_MINCELL_BIT  = 15;
  localparam int         DLY_W           = 16;
  localparam int         SETTLE_W        = 8;
  localparam int         CFG_SUSPEND_BIT = 0;
  localparam int         CFG_ALTMUX_BIT  = 1;
  localparam int         ST_REJECT_BIT   = 0;
  localparam int         ST_EXPIRED_BIT  = 1;
  localparam int         ST_SETTLING_BIT = 2;
  localparam int         ST_TIMER_LSB    = 16;

  // ------------------------------------------------------------------
  // Mode codes and reset values
  // ------------------------------------------------------------------
  localparam logic [2:0] MODE_OFF        = 3'h0;
  localparam logic [2:0] MODE_EMERGENCY  = 3'h1;
  localparam logic [9:0] EXP_WD_OFF      = 10'h3ff;
  localparam logic [9:0] TIMER_MAX       = 10'h3ff;
  localparam logic [9:0] EXP_RESET       = 10'h000;
  localparam logic [7:0] SETTLE_RESET    = 8'h00;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int         CLK_PERIOD_NS   = 100;
  localparam int         SETTLE_STEP_NS  = 96000;
  localparam int         STEP_CYCLES     = (SETTLE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         TICK_PERIOD_NS  = 1000000000;
  localparam int         TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SETTLE_IDLE = 2'b01,
    SETTLE_WAIT = 2'b10
  } settle_state_type;

endpackage
`default_nettype wire

//--- verilog/cell_balance_write_guard.sv
// Balancing mode register guard, manual switch control and settling delay
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Auto modes block balancing writes, most flagged
// - Manual/emergency reject expiry-one, emergency delay-ctrl too
// - Refresh strobe acts only in manual mode
// - Lowest-cell target blocks target writes while scanning
// - Nonzero mode write zeroes timer, relaunches
// - Manual switch: enable, not expired, not suspended
// - Manual timer counts real time regardless
// - Expiry-one all ones disables watchdog
// - Manual mode ignores undervoltage exit
// - Strobe after expiry does nothing
// - Adjacent switches never interlocked
// - Suspension gates switches in manual mode, and enables the settling delay in every mode
// - Upper byte cell delay, lower diagnostic
// - Mux select chooses cell or diagnostic delay
// - Settle register locked during scan or auto
// - Timer unaffected by suspension setting
// - Blocked write discarded, reject flag set except switch-ctrl writes without restart bit
// - Mode stays until rewritten
module cell_balance_write_guard #(
  parameter int TICK_CYCLES = cell_balance_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire  logic        mclk,
  input  wire  logic        rst,
  // Avalon-MM slave
  input  wire  logic [7:0]  address,
  input  wire  logic [3:0]  byteenable,
  input  wire  logic        read,
  input  wire  logic        write,
  input  wire  logic [31:0] writedata,
  output logic       [31:0] readdata,
  output logic              waitrequest,
  // Scan controller
  input  wire  logic        measBusy,
  input  wire  logic        acqRequest,
  output logic              measStart,
  output logic              settling,
  output logic              uvExitEnable,
  // Discharge switches
  output logic       [13:0] dischargeSwitch
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic isAuto(input logic [2:0] m);
    return m[2];
  endfunction

  function automatic logic isManual(input logic [2:0] m);
    return m[2:1] == 2'b01;
  endfunction

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  logic [2:0]  modeFf;
  logic [13:0] swEnableFf;
  logic [9:0]  expiryFf [cell_balance_pkg::CELLS];
  logic [11:0] uvTargetFf;
  logic        minCellFf;
  logic [15:0] delayCtrlFf;
  logic [7:0]  cellDelayFf;
  logic [7:0]  diagDelayFf;
  logic        suspendFf;
  logic        altMuxFf;
  logic        rejectFf;
  logic [9:0]  timerFf;
  logic [31:0] tickCntFf;
  logic        ackFf;
  logic [31:0] readFf;
  logic [13:0] switchFf;
  logic        measStartFf;
  logic [7:0]  stepsLeftFf;
  logic [15:0] stepCntFf;
  cell_balance_pkg::settle_state_type settleStateFf;
  cell_balance_pkg::settle_state_type nxt_settleState;

  // ------------------------------------------------------------------
  // Bus handshake: one wait state, then answer
  // ------------------------------------------------------------------
  wire logic        request   = read | write;
  wire logic        writeNow  = write & ackFf;
  wire logic [7:0]  wordIdx   = {2'b00, address[7:2]};
  wire logic        hitMode   = address == cell_balance_pkg::OFF_MODE;
  wire logic        hitSw     = address == cell_balance_pkg::OFF_SWCTRL;
  wire logic        hitExp    = (address >= cell_balance_pkg::OFF_EXP_FIRST)
                              && (address <= cell_balance_pkg::OFF_EXP_LAST)
                              && (address[1:0] == 2'b00);
  wire logic [3:0]  expSel    = wordIdx[3:0] - 4'h2;
  wire logic        hitUv     = address == cell_balance_pkg::OFF_UV_TARGET;
  wire logic        hitDly    = address == cell_balance_pkg::OFF_DELAY_CTRL;
  wire logic        hitSettle = address == cell_balance_pkg::OFF_SETTLE;
  wire logic        hitCfg    = address == cell_balance_pkg::OFF_CONFIG;
  wire logic        hitStatus = address == cell_balance_pkg::OFF_STATUS;
  wire logic [31:0] wrMerged  = mergeBytes(32'h0000_0000, writedata, byteenable);
  wire logic [31:0] swMerged  = mergeBytes({18'h0, swEnableFf}, writedata, byteenable);
  wire logic [31:0] uvMerged  = mergeBytes({20'h0, uvTargetFf}, writedata, byteenable);
  wire logic [31:0] dlyMerged = mergeBytes({16'h0, delayCtrlFf}, writedata, byteenable);
  wire logic [31:0] setMerged = mergeBytes({16'h0, cellDelayFf, diagDelayFf},
                                           writedata, byteenable);

  assign waitrequest = request & ~ackFf;

  // ------------------------------------------------------------------
  // Mode classification
  // ------------------------------------------------------------------
  wire logic modeAuto      = isAuto(modeFf);
  wire logic modeManual    = isManual(modeFf);
  wire logic modeEmergency = modeFf == cell_balance_pkg::MODE_EMERGENCY;
  wire logic measActive    = measBusy | settling;

  // ------------------------------------------------------------------
  // Write guard
  // ------------------------------------------------------------------
  wire logic restartBitWr = writedata[cell_balance_pkg::SW_RESTART_BIT] & byteenable[1];
  wire logic swReject     = modeAuto;
  wire logic swFlag       = modeAuto & restartBitWr;
  wire logic expReject    = modeAuto
                          | ((modeManual | modeEmergency) & (expSel == 4'h0));
  wire logic uvReject     = modeAuto | (minCellFf & measBusy);
  wire logic dlyReject    = modeAuto | modeEmergency;
  wire logic settleReject = modeAuto | measActive;
  wire logic rejectEvent  = writeNow & ((hitSw & swFlag) | (hitExp & expReject)
                          | (hitUv & uvReject) | (hitDly & dlyReject)
                          | (hitSettle & settleReject));
  wire logic rejectClear  = writeNow & hitStatus & byteenable[0]
                          & writedata[cell_balance_pkg::ST_REJECT_BIT];

  // ------------------------------------------------------------------
  // Balancing timer and watchdog
  // ------------------------------------------------------------------
  wire logic modeWrite   = writeNow & hitMode & byteenable[0];
  wire logic [2:0] nxt_mode = writedata[2:0];
  wire logic tick        = tickCntFf == 32'(TICK_CYCLES - 1);
  wire logic wdOff       = expiryFf[0] == cell_balance_pkg::EXP_WD_OFF;
  wire logic expired     = timerFf > expiryFf[0];
  wire logic refresh     = writeNow & hitSw & restartBitWr & modeManual & ~expired;
  wire logic timerRun    = (modeFf != cell_balance_pkg::MODE_OFF)
                         & (timerFf != cell_balance_pkg::TIMER_MAX);

  // ------------------------------------------------------------------
  // Manual switch equation
  // ------------------------------------------------------------------
  wire logic        wdAllows  = ~expired | wdOff;
  wire logic        suspended = suspendFf & measActive;
  wire logic [13:0] nxt_switch = (modeManual & wdAllows & ~suspended)
                               ? swEnableFf : 14'h0000;

  assign uvExitEnable = modeAuto;

  // ------------------------------------------------------------------
  // Settling delay selection
  // ------------------------------------------------------------------
  wire logic [7:0] chosenDelay = ~suspendFf ? 8'h00
                               : (altMuxFf ? diagDelayFf : cellDelayFf);
  wire logic       stepDone    = stepCntFf == 16'(cell_balance_pkg::STEP_CYCLES - 1);
  wire logic       settleStartNow = (settleStateFf == cell_balance_pkg::SETTLE_IDLE)
                                  & acqRequest & (chosenDelay == 8'h00);
  wire logic       settleEndNow   = (settleStateFf == cell_balance_pkg::SETTLE_WAIT)
                                  & stepDone & (stepsLeftFf == 8'h01);

  always_comb begin
    nxt_settleState = settleStateFf;
    case (settleStateFf)
      cell_balance_pkg::SETTLE_IDLE: begin
        if (acqRequest && chosenDelay != 8'h00) begin
          nxt_settleState = cell_balance_pkg::SETTLE_WAIT;
        end
      end
      cell_balance_pkg::SETTLE_WAIT: begin
        if (settleEndNow) begin
          nxt_settleState = cell_balance_pkg::SETTLE_IDLE;
        end
      end
      default: nxt_settleState = cell_balance_pkg::SETTLE_IDLE;
    endcase
  end

  assign settling  = settleStateFf == cell_balance_pkg::SETTLE_WAIT;
  assign measStart = measStartFf;

  always_ff @(posedge mclk) begin
    if (rst) begin
      settleStateFf <= cell_balance_pkg::SETTLE_IDLE;
      stepsLeftFf   <= 8'h00;
      stepCntFf     <= 16'h0000;
      measStartFf   <= 1'b0;
    end else begin
      settleStateFf <= nxt_settleState;
      measStartFf   <= settleStartNow | settleEndNow;
      if (settleStateFf == cell_balance_pkg::SETTLE_IDLE) begin
        stepsLeftFf <= chosenDelay;
        stepCntFf   <= 16'h0000;
      end else if (stepDone) begin
        stepsLeftFf <= stepsLeftFf - 8'h01;
        stepCntFf   <= 16'h0000;
      end else begin
        stepCntFf   <= stepCntFf + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------------
  wire logic [31:0] rdMux =
      hitMode   ? {29'h0, modeFf}
    : hitSw     ? {2'h0, switchFf, 2'h0, swEnableFf}
    : hitExp    ? {22'h0, expiryFf[expSel]}
    : hitUv     ? {16'h0, minCellFf, 3'h0, uvTargetFf}
    : hitDly    ? {16'h0, delayCtrlFf}
    : hitSettle ? {16'h0, cellDelayFf, diagDelayFf}
    : hitCfg    ? {30'h0, altMuxFf, suspendFf}
    : hitStatus ? {6'h0, timerFf, 13'h0, settling, expired, rejectFf}
    : 32'h0000_0000;

  assign readdata        = readFf;
  assign dischargeSwitch = switchFf;

  // ------------------------------------------------------------------
  // Bus and status flops
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      ackFf    <= 1'b0;
      readFf   <= 32'h0000_0000;
      rejectFf <= 1'b0;
      switchFf <= 14'h0000;
    end else begin
      ackFf    <= request & ~ackFf;
      readFf   <= (read & ~ackFf) ? rdMux : readFf;
      rejectFf <= (rejectFf & ~rejectClear) | rejectEvent;
      switchFf <= nxt_switch;
    end
  end

  // Timer keeps counting whatever the switches or suspension do
  always_ff @(posedge mclk) begin
    if (rst) begin
      modeFf    <= cell_balance_pkg::MODE_OFF;
      timerFf   <= 10'h000;
      tickCntFf <= 32'h0000_0000;
    end else begin
      if (modeWrite) begin
        modeFf <= nxt_mode;
      end
      if (modeWrite || refresh) begin
        timerFf   <= 10'h000;
        tickCntFf <= 32'h0000_0000;
      end else begin
        tickCntFf <= tick ? 32'h0000_0000 : tickCntFf + 32'h0000_0001;
        if (tick && timerRun) begin
          timerFf <= timerFf + 10'h001;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      swEnableFf  <= 14'h0000;
      uvTargetFf  <= 12'h000;
      minCellFf   <= 1'b0;
      delayCtrlFf <= 16'h0000;
      cellDelayFf <= cell_balance_pkg::SETTLE_RESET;
      diagDelayFf <= cell_balance_pkg::SETTLE_RESET;
      suspendFf   <= 1'b0;
      altMuxFf    <= 1'b0;
    end else if (writeNow) begin
      if (hitSw && !swReject) begin
        swEnableFf <= swMerged[cell_balance_pkg::CELLS-1:0];
      end
      if (hitUv && !uvReject) begin
        {minCellFf, uvTargetFf} <= {wrMerged[cell_balance_pkg::UV_MINCELL_BIT],
                                    uvMerged[cell_balance_pkg::UV_W-1:0]};
      end
      if (hitDly && !dlyReject) begin
        delayCtrlFf <= dlyMerged[15:0];
      end
      if (hitSettle && !settleReject) begin
        {cellDelayFf, diagDelayFf} <= setMerged[15:0];
      end
      if (hitCfg && byteenable[0]) begin
        suspendFf <= writedata[cell_balance_pkg::CFG_SUSPEND_BIT];
        altMuxFf  <= writedata[cell_balance_pkg::CFG_ALTMUX_BIT];
      end
    end
  end

  // ------------------------------------------------------------------
  // Expiry registers
  // ------------------------------------------------------------------
  for (genvar n = 0; n < cell_balance_pkg::CELLS; n++) begin : g_exp
    wire logic [31:0] expMerged = mergeBytes({22'h0, expiryFf[n]}, writedata, byteenable);
    always_ff @(posedge mclk) begin
      if (rst) begin
        expiryFf[n] <= cell_balance_pkg::EXP_RESET;
      end else if (writeNow && hitExp && !expReject && expSel == 4'(n)) begin
        expiryFf[n] <= expMerged[9:0];
      end
    end
  end

endmodule // cell_balance_write_guard
`default_nettype wire
